// File: pll_consts.svh
// Constants of the fractional-N synthesizer core: field positions, reset values, timing.
`ifndef PLL_CONSTS_SVH
`define PLL_CONSTS_SVH

// ==========================================================
// Destination codes in the three low bits of a word
`define SEL_FRACTION_WORD_INT 3'h0
`define SEL_MOD_R 3'h1
`define SEL_FUNCTION 3'h3
`define SEL_TIMER 3'h4
`define SEL_MUX 3'h6

// ==========================================================
// Field positions
`define WORD_BITS 24
`define INT_MSB 22
`define INT_LSB 15
`define FRACTION_WORD_MSB 14
`define FRACTION_WORD_LSB 3
`define HALF_BIT 22
`define PRESC_BIT 20
`define DOUBLER_BIT 19
`define RDIV_MSB 18
`define RDIV_LSB 15
`define MODW_MSB 14
`define MODW_LSB 3
`define POL_BIT 3
`define TVAL_MSB 13
`define TVAL_LSB 5
`define TSEL_MSB 4
`define TSEL_LSB 3
`define MSEL_MSB 6
`define MSEL_LSB 3

// ==========================================================
// Timer selects and output select codes
`define TSEL_SW_AB 2'h0
`define TSEL_SW_C 2'h1
`define TSEL_PUMP 2'h2
`define MSEL_LOW 4'h0
`define MSEL_HIGH 4'h1
`define MSEL_RDIV 4'h2
`define MSEL_NDIV 4'h3
`define MSEL_LOCK 4'h4
`define MSEL_PFDREF 4'h5

// ==========================================================
// Reset values and the fast-lock pump cell load
`define RST_INT 8'h1A
`define RST_FRACTION_WORD 12'h000
`define RST_MODW 12'h002
`define RST_RDIV 4'h1
`define RST_CELLS 7'h01
`define ALL_CELLS 7'h40

// ==========================================================
// Timing
`define CLK_PERIOD_NS 20
`define LOCK_ERR_NS 3
`define UNLOCK_ERR_NS 30
`define LOCK_ERR_CYC ((`LOCK_ERR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UNLOCK_ERR_CYC (`UNLOCK_ERR_NS / `CLK_PERIOD_NS)
`define LOCK_CYCLES 40
`define TIMER_PRESCALE 4

`endif

// File: pll_pkg.sv
// Types shared by the synthesizer core.
package pll_pkg;

  typedef struct packed {
    logic doubler;
    logic half;
    logic [3:0] r_div;
  } ref_cfg_t;

  typedef struct packed {
    logic [7:0] int_w;
    logic [11:0] fraction_word_w;
    logic [11:0] mod_w;
    logic presc_89;
  } fb_cfg_t;

  typedef enum logic [1:0] {
    FL_NORMAL = 2'b00,
    FL_WIDE = 2'b01,
    FL_STEP = 2'b10
  } fl_state_t;

endpackage

// File: fraction_word_pll_core.sv
// Digital core of a fractional-N synthesizer with fast-lock sequencing.
// ==========================================================
`timescale 1ns/1ps
`include "pll_consts.svh"

module fraction_word_pll_core
  import pll_pkg::*;
#(
  parameter int TIMER_W = 9,
  parameter int LOCK_COUNT = `LOCK_CYCLES
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Loop signals
  input wire logic REFERENCE_INPUT,
  input wire logic VCO_FEEDBACK,
  // Serial programming
  input wire logic SERIAL_CLOCK,
  input wire logic SERIAL_DATA,
  input wire logic LOAD_STROBE,
  // Phase detector, pump and prescaler control
  output logic PUMP_UP,
  output logic PUMP_DOWN,
  output logic [6:0] PUMP_CELLS,
  output logic PRESCALER_89,
  // Loop filter switches
  output logic FILTER_SWITCH_A,
  output logic FILTER_SWITCH_B,
  output logic FILTER_SWITCH_C,
  // Status
  output logic LOCK_DETECT,
  output logic MULTIPLEXED_OUTPUT
);

  // ==========================================================
  // Serial interface and programming words
  logic [23:0] shift_q, shift_d;
  logic sclk_q, le_q;
  ref_cfg_t ref_cfg_q, ref_cfg_d;
  fb_cfg_t fb_cfg_q, fb_cfg_d;
  logic pol_q, pol_d;
  logic [3:0] output_select_field_q, output_select_field_d;
  logic [TIMER_W-1:0] tprog_q [3];
  logic [TIMER_W-1:0] tprog_d [3];
  logic new_freq;
  logic load_now;

  always_comb
  begin
    shift_d = shift_q;
    ref_cfg_d = ref_cfg_q;
    fb_cfg_d = fb_cfg_q;
    pol_d = pol_q;
    output_select_field_d = output_select_field_q;
    tprog_d = tprog_q;
    new_freq = 1'b0;
    load_now = LOAD_STROBE && !le_q;
    if (SERIAL_CLOCK && !sclk_q)
    begin
      shift_d = {shift_q[22:0], SERIAL_DATA};
    end
    if (load_now)
    begin
      case (shift_q[2:0])
        `SEL_FRACTION_WORD_INT:
        begin
          fb_cfg_d.int_w = shift_q[`INT_MSB:`INT_LSB];
          fb_cfg_d.fraction_word_w = shift_q[`FRACTION_WORD_MSB:`FRACTION_WORD_LSB];
          new_freq = 1'b1;
        end
        `SEL_MOD_R:
        begin
          ref_cfg_d.half = shift_q[`HALF_BIT];
          fb_cfg_d.presc_89 = shift_q[`PRESC_BIT];
          ref_cfg_d.doubler = shift_q[`DOUBLER_BIT];
          ref_cfg_d.r_div = shift_q[`RDIV_MSB:`RDIV_LSB];
          fb_cfg_d.mod_w = shift_q[`MODW_MSB:`MODW_LSB];
        end
        `SEL_FUNCTION: pol_d = shift_q[`POL_BIT];
        `SEL_TIMER:
        begin
          if (shift_q[`TSEL_MSB:`TSEL_LSB] != 2'h3)
          begin
            tprog_d[shift_q[`TSEL_MSB:`TSEL_LSB]] = shift_q[`TVAL_MSB:`TVAL_LSB];
          end
        end
        `SEL_MUX: output_select_field_d = shift_q[`MSEL_MSB:`MSEL_LSB];
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      shift_q <= 24'h000000;
      // Track the pins in reset so an idle-high clock gives no false edge
      sclk_q <= SERIAL_CLOCK;
      le_q <= LOAD_STROBE;
      ref_cfg_q <= '{doubler: 1'b0, half: 1'b0, r_div: `RST_RDIV};
      fb_cfg_q <= '{int_w: `RST_INT, fraction_word_w: `RST_FRACTION_WORD, mod_w: `RST_MODW, presc_89: 1'b0};
      pol_q <= 1'b1;
      output_select_field_q <= `MSEL_LOW;
      tprog_q <= '{default: '0};
    end
    else
    begin
      shift_q <= shift_d;
      sclk_q <= SERIAL_CLOCK;
      le_q <= LOAD_STROBE;
      ref_cfg_q <= ref_cfg_d;
      fb_cfg_q <= fb_cfg_d;
      pol_q <= pol_d;
      output_select_field_q <= output_select_field_d;
      tprog_q <= tprog_d;
    end
  end

  // ==========================================================
  // Reference path: doubler, counter, toggle stage, timer clock
  logic reference_input_q;
  logic [3:0] rcnt_q, rcnt_d;
  logic pfd_ref_q, pfd_ref_d, pfd_prev_q;
  logic [1:0] tdiv_q, tdiv_d;
  logic ref_ev, r_out, pfd_rise, pfd_fall, timer_tick;
  logic [3:0] r_last;

  always_comb
  begin
    // Doubler counts both input edges, so a full ratio of 0.5 is reachable
    ref_ev = ref_cfg_q.doubler ? (REFERENCE_INPUT ^ reference_input_q)
                               : (REFERENCE_INPUT && !reference_input_q);
    // A zero divide code behaves as one
    r_last = (ref_cfg_q.r_div == 4'h0) ? 4'h0 : ref_cfg_q.r_div - 4'h1;
    r_out = ref_ev && (rcnt_q == r_last);
    rcnt_d = rcnt_q;
    if (ref_ev)
    begin
      rcnt_d = r_out ? 4'h0 : rcnt_q + 4'h1;
    end
    // Without the toggle stage the reference is a one-cycle pulse
    pfd_ref_d = ref_cfg_q.half ? (pfd_ref_q ^ r_out) : r_out;
    pfd_rise = pfd_ref_q && !pfd_prev_q;
    pfd_fall = !pfd_ref_q && pfd_prev_q;
    tdiv_d = pfd_fall ? tdiv_q + 2'h1 : tdiv_q;
    timer_tick = pfd_fall && (tdiv_q == 2'(`TIMER_PRESCALE - 1));
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      reference_input_q <= 1'b0;
      rcnt_q <= 4'h0;
      pfd_ref_q <= 1'b0;
      pfd_prev_q <= 1'b0;
      tdiv_q <= 2'h0;
    end
    else
    begin
      reference_input_q <= REFERENCE_INPUT;
      rcnt_q <= rcnt_d;
      pfd_ref_q <= pfd_ref_d;
      pfd_prev_q <= pfd_ref_q;
      tdiv_q <= tdiv_d;
    end
  end

  // ==========================================================
  // Feedback divider with third-order modulator
  function automatic logic [12:0] mod_add(input logic [11:0] a, input logic [11:0] b,
                                          input logic [11:0] m);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, m})
    begin
      mod_add = {1'b1, 12'(s - {1'b0, m})};
    end
    else
    begin
      mod_add = {1'b0, s[11:0]};
    end
  endfunction

  logic vco_q;
  logic [9:0] fcnt_q, fcnt_d, nlen_q, nlen_d;
  logic [11:0] acc_q [3];
  logic [11:0] acc_d [3];
  logic c2_q, c3_q, c3_qq, c2_d, c3_d, c3_dd;
  logic [12:0] s1, s2, s3;
  logic signed [3:0] sd;
  logic ndiv_out;

  always_comb
  begin
    ndiv_out = VCO_FEEDBACK && !vco_q && (fcnt_q >= nlen_q - 10'h001);
    fcnt_d = fcnt_q;
    nlen_d = nlen_q;
    acc_d = acc_q;
    c2_d = c2_q;
    c3_d = c3_q;
    c3_dd = c3_qq;
    s1 = mod_add(acc_q[0], fb_cfg_q.fraction_word_w, fb_cfg_q.mod_w);
    s2 = mod_add(acc_q[1], s1[11:0], fb_cfg_q.mod_w);
    s3 = mod_add(acc_q[2], s2[11:0], fb_cfg_q.mod_w);
    // Cascade noise shaping: carries average to fraction_word over mod
    sd = 4'(s1[12]) + 4'(s2[12]) - 4'(c2_q) + 4'(s3[12]) - 4'(2 * c3_q) + 4'(c3_qq);
    if (VCO_FEEDBACK && !vco_q)
    begin
      fcnt_d = ndiv_out ? 10'h000 : fcnt_q + 10'h001;
    end
    if (ndiv_out)
    begin
      acc_d[0] = s1[11:0];
      acc_d[1] = s2[11:0];
      acc_d[2] = s3[11:0];
      c2_d = s2[12];
      c3_d = s3[12];
      c3_dd = c3_q;
      nlen_d = {2'h0, fb_cfg_q.int_w} + 10'(sd);
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      vco_q <= 1'b0;
      fcnt_q <= 10'h000;
      nlen_q <= {2'h0, `RST_INT};
      acc_q <= '{default: '0};
      c2_q <= 1'b0;
      c3_q <= 1'b0;
      c3_qq <= 1'b0;
    end
    else
    begin
      vco_q <= VCO_FEEDBACK;
      fcnt_q <= fcnt_d;
      nlen_q <= nlen_d;
      acc_q <= acc_d;
      c2_q <= c2_d;
      c3_q <= c3_d;
      c3_qq <= c3_dd;
    end
  end

  // ==========================================================
  // Phase detector and digital lock detect
  logic up_q, up_d, dn_q, dn_d, lock_q, lock_d;
  logic [7:0] err_q, err_d;
  logic [5:0] good_q, good_d;
  logic pfd_clear;

  always_comb
  begin
    up_d = up_q | pfd_rise;
    dn_d = dn_q | ndiv_out;
    pfd_clear = up_d && dn_d;
    err_d = (up_q ^ dn_q) && (err_q != 8'hFF) ? err_q + 8'h01 : err_q;
    good_d = good_q;
    lock_d = lock_q;
    if (pfd_clear)
    begin
      // Pulse width difference is the phase error
      up_d = 1'b0;
      dn_d = 1'b0;
      err_d = 8'h00;
      if (err_q > 8'(`UNLOCK_ERR_CYC))
      begin
        good_d = 6'h00;
        lock_d = 1'b0;
      end
      else if (err_q < 8'(`LOCK_ERR_CYC))
      begin
        good_d = (good_q == 6'(LOCK_COUNT)) ? good_q : good_q + 6'h01;
        lock_d = lock_q || (good_q + 6'h01 >= 6'(LOCK_COUNT));
      end
      else
      begin
        good_d = 6'h00;
      end
    end
    // A stuck pulse must drop lock without waiting for the other edge
    if (err_q > 8'(`UNLOCK_ERR_CYC))
    begin
      good_d = 6'h00;
      lock_d = 1'b0;
    end
    if (new_freq)
    begin
      good_d = 6'h00;
      lock_d = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
      err_q <= 8'h00;
      good_q <= 6'h00;
      lock_q <= 1'b0;
    end
    else
    begin
      up_q <= up_d;
      dn_q <= dn_d;
      err_q <= err_d;
      good_q <= good_d;
      lock_q <= lock_d;
    end
  end

  // ==========================================================
  // Fast-lock timeout counters and pump cell stepping
  fl_state_t fl_q, fl_d;
  logic [TIMER_W-1:0] tcnt_q [3];
  logic [TIMER_W-1:0] tcnt_d [3];
  logic [6:0] cells_q, cells_d;

  always_comb
  begin
    fl_d = fl_q;
    tcnt_d = tcnt_q;
    cells_d = cells_q;
    if (new_freq)
    begin
      // A write mid-sequence simply starts over
      tcnt_d = tprog_q;
      cells_d = `ALL_CELLS;
      fl_d = FL_WIDE;
    end
    else if (timer_tick)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (tcnt_q[i] != '0)
        begin
          tcnt_d[i] = tcnt_q[i] - 1'b1;
        end
      end
      case (fl_q)
        FL_WIDE:
        begin
          if (tcnt_q[`TSEL_PUMP] == '0)
          begin
            cells_d = cells_q >> 1;
            fl_d = FL_STEP;
          end
        end
        FL_STEP:
        begin
          cells_d = cells_q >> 1;
          if (cells_q == 7'h02)
          begin
            fl_d = FL_NORMAL;
          end
        end
        default: fl_d = FL_NORMAL;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      fl_q <= FL_NORMAL;
      tcnt_q <= '{default: '0};
      cells_q <= `RST_CELLS;
    end
    else
    begin
      fl_q <= fl_d;
      tcnt_q <= tcnt_d;
      cells_q <= cells_d;
    end
  end

  // ==========================================================
  // Outputs
  logic mux_q, mux_d;

  always_comb
  begin
    case (output_select_field_q)
      `MSEL_HIGH: mux_d = 1'b1;
      `MSEL_RDIV: mux_d = r_out;
      `MSEL_NDIV: mux_d = ndiv_out;
      `MSEL_LOCK: mux_d = lock_q;
      `MSEL_PFDREF: mux_d = pfd_ref_q;
      default: mux_d = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      mux_q <= 1'b0;
    end
    else
    begin
      mux_q <= mux_d;
    end
  end

  assign MULTIPLEXED_OUTPUT = mux_q;
  assign PUMP_UP = pol_q ? up_q : dn_q;
  assign PUMP_DOWN = pol_q ? dn_q : up_q;
  assign PUMP_CELLS = cells_q;
  assign PRESCALER_89 = fb_cfg_q.presc_89;
  assign FILTER_SWITCH_A = (tcnt_q[`TSEL_SW_AB] != '0);
  assign FILTER_SWITCH_B = (tcnt_q[`TSEL_SW_AB] != '0);
  assign FILTER_SWITCH_C = (tcnt_q[`TSEL_SW_C] != '0);
  assign LOCK_DETECT = lock_q;

endmodule

// File: pll_core_sva.sv
// Assertions on the output pins of the synthesizer core.
`timescale 1ns/1ps
module pll_core_sva
#(
  parameter int LOCK_COUNT = 40
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Watched outputs
  input wire logic PUMP_UP,
  input wire logic PUMP_DOWN,
  input wire logic [6:0] PUMP_CELLS,
  input wire logic FILTER_SWITCH_A,
  input wire logic FILTER_SWITCH_B,
  input wire logic LOCK_DETECT
);
  // ==========================================================
  // Cycles since the last pump pulse, saturating so it never wraps
  int quiet_q;
  int quiet_d;
  always_comb
  begin
    quiet_d = quiet_q < 1000 ? quiet_q + 1 : quiet_q;
    if (PUMP_UP || PUMP_DOWN)
      quiet_d = 0;
  end
  always_ff @(posedge REF_CLK)
  begin
    quiet_q <= SYS_RST ? 0 : quiet_d;
  end
  // ==========================================================
  // Properties
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  AST_RST_STATE: assert property ($fell(SYS_RST) |-> PUMP_CELLS == 7'h01
    && !FILTER_SWITCH_A && !LOCK_DETECT) else $error("bad state after reset");
  AST_CELLS_ONEHOT: assert property ($onehot(PUMP_CELLS))
    else $error("cell count not a power of two");
  AST_CELLS_STEP: assert property ($changed(PUMP_CELLS) && !$past(SYS_RST) |->
    PUMP_CELLS == 7'h40 || PUMP_CELLS == $past(PUMP_CELLS) >> 1) else $error("bad cell step");
  AST_SW_PAIR: assert property (FILTER_SWITCH_A == FILTER_SWITCH_B)
    else $error("switch pair split");
  AST_SW_CLOSE: assert property ($rose(FILTER_SWITCH_A) |-> PUMP_CELLS == 7'h40)
    else $error("switch closed without fast lock");
  AST_PUMP_EXCL: assert property (!(PUMP_UP && PUMP_DOWN))
    else $error("up and down together");
  AST_NEW_UNLOCK: assert property ($changed(PUMP_CELLS) && PUMP_CELLS == 7'h40 |->
    !LOCK_DETECT) else $error("lock held over new channel");
  AST_LOCK_RISE: assert property ($rose(LOCK_DETECT) |-> quiet_q >= LOCK_COUNT)
    else $error("lock too early");
  AST_LOCK_BAD: assert property ((PUMP_UP || PUMP_DOWN) [*3] |->
    ##[1:2] !LOCK_DETECT) else $error("lock survived large error");
endmodule

bind fraction_word_pll_core pll_core_sva #(.LOCK_COUNT(LOCK_COUNT)) u_sva (
  .REF_CLK(REF_CLK),
  .SYS_RST(SYS_RST),
  .PUMP_UP(PUMP_UP),
  .PUMP_DOWN(PUMP_DOWN),
  .PUMP_CELLS(PUMP_CELLS),
  .FILTER_SWITCH_A(FILTER_SWITCH_A),
  .FILTER_SWITCH_B(FILTER_SWITCH_B),
  .LOCK_DETECT(LOCK_DETECT)
);

// File: pll_far_side.sv
// Reference oscillator and VCO model driving the core's loop inputs.
`timescale 1ns/1ps
module pll_far_side
(
  // Clock and half periods in system cycles
  input wire logic REF_CLK,
  input wire logic [7:0] ref_half,
  input wire logic [7:0] vco_half,
  // Waveforms
  output logic REFERENCE_INPUT,
  output logic VCO_FEEDBACK
);
  int rc = 0;
  int vc = 0;
  initial
  begin
    REFERENCE_INPUT = 1'b0;
    VCO_FEEDBACK = 1'b0;
  end
  // Reference kept far below 120 MHz, so halving stays optional
  always @(posedge REF_CLK)
  begin
    #1;
    rc = rc + 1;
    vc = vc + 1;
    if (rc >= ref_half)
    begin
      rc = 0;
      REFERENCE_INPUT = ~REFERENCE_INPUT;
    end
    // A stopped VCO holds the feedback low, so no rising edges follow
    if (vco_half == 8'h00)
      VCO_FEEDBACK = 1'b0;
    else if (vc >= vco_half)
    begin
      vc = 0;
      VCO_FEEDBACK = ~VCO_FEEDBACK;
    end
  end
endmodule

// File: fraction_word_pll_core_tb.sv
// Self-checking bench of the synthesizer core.
`timescale 1ns/1ps
`include "pll_consts.svh"
`define CHK(a, b) \
  begin \
    check_count++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("CHECK FAILED at %0t: value mismatch", $time); \
    end \
  end
module fraction_word_pll_core_tb
  import pll_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk = 1'b1;
  logic sdat = 1'b0;
  logic ld = 1'b0;
  logic [7:0] ref_half = 8'h02;
  logic [7:0] vco_half = 8'h01;
  logic ref_w, vco_w, pup, pdn, p89, sw_a, sw_b, sw_c, lock, mux;
  logic [6:0] cells;
  int fails = 0;
  int check_count = 0;
  int n, up, dn, hi;
  always #10 clk = ~clk;
  pll_far_side u_far (.REF_CLK(clk), .ref_half(ref_half), .vco_half(vco_half),
    .REFERENCE_INPUT(ref_w), .VCO_FEEDBACK(vco_w));
  fraction_word_pll_core u_dut (.REF_CLK(clk), .SYS_RST(rst), .REFERENCE_INPUT(ref_w),
    .VCO_FEEDBACK(vco_w), .SERIAL_CLOCK(sclk), .SERIAL_DATA(sdat), .LOAD_STROBE(ld),
    .PUMP_UP(pup), .PUMP_DOWN(pdn), .PUMP_CELLS(cells), .PRESCALER_89(p89),
    .FILTER_SWITCH_A(sw_a), .FILTER_SWITCH_B(sw_b), .FILTER_SWITCH_C(sw_c),
    .LOCK_DETECT(lock), .MULTIPLEXED_OUTPUT(mux));
  // ==========================================================
  // Access tasks
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Each serial level is held two system cycles so every edge is sampled
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--)
    begin
      sclk = 1'b0;
      sdat = w[i];
      step(2);
      sclk = 1'b1;
      step(2);
    end
    ld = 1'b1;
    step(2);
    ld = 1'b0;
    step(2);
  endtask
  function automatic logic [23:0] w0(input logic [7:0] i, input logic [11:0] f);
    return {1'b0, i, f, `SEL_FRACTION_WORD_INT};
  endfunction
  // Prescaler 8/9 and modulus 2 always set
  function automatic logic [23:0] w1(input logic hf, input logic dbl, input logic [3:0] r);
    return {1'b0, hf, 1'b0, 1'b1, dbl, r, 12'h002, `SEL_MOD_R};
  endfunction
  function automatic logic [23:0] w4(input logic [8:0] v, input logic [1:0] s);
    return {10'h000, v, s, `SEL_TIMER};
  endfunction
  function automatic logic [23:0] w6(input logic [3:0] s);
    return {17'h00000, s, `SEL_MUX};
  endfunction
  // Cycles spanned by k periods of the multiplexed output
  task automatic span(input int k, output int c);
    int r;
    logic p;
    r = -1;
    c = 0;
    p = mux;
    while (r < k && c < 20000)
    begin
      step(1);
      if (r >= 0)
        c++;
      if (mux === 1'b1 && p === 1'b0)
        r++;
      p = mux;
    end
  endtask
  task automatic count(input int k);
    up = 0;
    dn = 0;
    hi = 0;
    repeat (k)
    begin
      step(1);
      up += (pup === 1'b1);
      dn += (pdn === 1'b1);
      hi += (mux === 1'b1);
    end
  endtask
  task automatic wait_cells(output int c);
    logic [6:0] p;
    p = cells;
    c = 0;
    while (cells === p && c < 5000)
    begin
      step(1);
      c++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial
  begin
    step(12);
    rst = 1'b0;
    step(1);
    `CHK(cells, 7'h01)
    `CHK({sw_a, sw_b, sw_c, lock, pup, pdn, mux, p89}, 8'h00)
    $display("test reset done");
    send(w6(`MSEL_RDIV));
    send(w1(1'b0, 1'b0, 4'h3));
    `CHK(p89, 1'b1)
    span(4, n);
    `CHK(n, 48)
    send(w1(1'b0, 1'b1, 4'h3));
    span(4, n);
    `CHK(n, 24)
    send(w6(`MSEL_PFDREF));
    send(w1(1'b1, 1'b0, 4'h3));
    span(2, n);
    `CHK(n, 48)
    count(48);
    `CHK(hi, 24)
    $display("test reference done");
    send(w6(`MSEL_HIGH));
    `CHK(mux, 1'b1)
    send(w6(`MSEL_LOCK));
    `CHK(mux, 1'b0)
    send(w6(4'hF));
    `CHK(mux, 1'b0)
    $display("test mux done");
    send(w6(`MSEL_NDIV));
    send(w0(8'h1E, 12'h000));
    span(4, n);
    `CHK(n, 240)
    send(w0(8'hFF, 12'h000));
    span(2, n);
    `CHK(n, 1020)
    send(w0(8'h1E, 12'h001));
    span(8, n);
    `CHK(n, 488)
    $display("test feedback done");
    send(w1(1'b1, 1'b0, 4'h8));
    vco_half = 8'h00;
    count(600);
    `CHK(up > 0 && dn == 0, 1'b1)
    `CHK(lock, 1'b0)
    // A slower reference keeps the feedback well ahead in every phase
    ref_half = 8'h04;
    vco_half = 8'h01;
    count(2000);
    `CHK(dn > up, 1'b1)
    ref_half = 8'h02;
    $display("test detector done");
    send(w1(1'b0, 1'b0, 4'h1));
    send(w4(9'h003, `TSEL_PUMP));
    send(w4(9'h00A, `TSEL_SW_AB));
    send(w4(9'h002, `TSEL_SW_C));
    send(w0(8'h1A, 12'h000));
    `CHK(cells, 7'h40)
    `CHK({sw_a, sw_b, sw_c}, 3'h7)
    n = 0;
    while (sw_c === 1'b1 && n < 500)
    begin
      step(1);
      n++;
    end
    `CHK(sw_c, 1'b0)
    `CHK(cells, 7'h40)
    wait_cells(n);
    repeat (5)
    begin
      wait_cells(n);
      `CHK(n, 16)
    end
    `CHK(cells, 7'h01)
    n = 0;
    while (sw_a === 1'b1 && n < 500)
    begin
      step(1);
      n++;
    end
    `CHK({sw_b, cells}, 8'h01)
    send(w0(8'h1A, 12'h000));
    wait_cells(n);
    send(w0(8'h1A, 12'h000));
    `CHK({sw_a, sw_b, sw_c, cells}, 10'h3C0)
    $display("test fast lock done");
    tally_and_finish();
  end
  initial
  begin
    #1000000;
    fails++;
    tally_and_finish();
  end
endmodule
